// ===== verilog/esf_fault_top.sv
// esf_fault_top: emergency-stop alarm and program-start error supervision
// assumes pins are asynchronous; the program engine reports done/empty/bad
// Notes on behaviour
// - estop alarm active forces servo off and dynamic brake on.
// - estop alarm clears by itself when the estop input goes inactive.
// - estop input normally closed by default; open input means alarm.
// - start while busy is ignored and reports subcode 0.
// - start input passes a configurable anti-chatter filter.
// - start on an empty channel runs nothing, reports subcode 1.
// - unrunnable command or bad data in channel reports subcode 2.
// - start refused with subcode 3 while stop is on or alarm present.
// - alarm-clear input or clear-alarm command clears program error.
// - each error code and subcode is written to the alarm history, except an estop rise in the same cycle as a program error.
`timescale 1ns/1ps
`default_nettype none
module esf_fault_top
	import esf_pkg::*;
#(
	parameter int DEBOUNCE_CYC = ESF_DEBOUNCE_CYC
)
(
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// pins from the host controller
	input wire logic i_emergency_stop_input,
	input wire logic i_stop_input,
	input wire logic i_alarm_clear_input,
	input wire logic i_program_start,
	input wire logic [ESF_CH_W-1:0] i_program_channel_select,
	// program engine status (same clock)
	input wire logic i_servo_on,
	input wire logic i_chan_empty,
	input wire logic i_chan_bad,
	input wire logic i_other_alarm,
	input wire logic i_prog_done,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// outputs to the drive and the engine
	output logic o_servo_enable,
	output logic o_dyn_brake,
	output logic o_estop_alarm,
	output logic o_busy,
	output logic o_prog_start,
	output logic [ESF_CH_W-1:0] o_prog_channel,
	output logic o_prog_error,
	output logic [1:0] o_prog_subcode,
	output logic o_irq
);
	// pin synchronisers: first stage feeds only the second
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [ESF_CH_W-1:0] sel1_reg;
	logic [ESF_CH_W-1:0] sel2_reg;
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sel1_reg <= '0;
			sel2_reg <= '0;
		end
		else if (i_ce)
		begin
			sync1_reg <= {i_program_start, i_alarm_clear_input, i_stop_input,
				i_emergency_stop_input};
			sync2_reg <= sync1_reg;
			sel1_reg <= i_program_channel_select;
			sel2_reg <= sel1_reg;
		end
	end
	wire estop_pin = sync2_reg[0];
	wire stop_on = sync2_reg[1];
	wire alarm_clear_input_on = sync2_reg[2];
	wire start_raw = sync2_reg[3];

	// registers
	logic [31:0] ctrl_reg;
	logic [ESF_TMR_W-1:0] deb_reg;
	logic [ESF_IRQ_W-1:0] irq_stat_reg;
	logic [ESF_IRQ_W-1:0] irq_mask_reg;
	logic estop_reg;
	logic busy_reg;
	logic perr_reg;
	esf_sub_t sub_reg;
	logic start_reg;
	logic [ESF_CH_W-1:0] chan_reg;
	logic level_d_reg;
	logic alarm_clear_input_d_reg;
	logic [31:0] rdata_reg;
	logic [ESF_HIST_AW-1:0] hwp_reg;
	logic [7:0] hcnt_reg;
	logic [7:0] hist_mem [ESF_HIST_DEPTH];

	// anti-chatter filter on the start pin
	esf_ctrl_if dbi ();
	assign dbi.limit = deb_reg;
	assign dbi.raw = start_raw;
	esf_debounce u_deb (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.dbi(dbi)
	);

	// decode
	wire wr_ctrl = i_wr && (i_addr == ESF_ADR_CTRL);
	wire wr_mask = i_wr && (i_addr == ESF_ADR_IRQ_MASK);
	wire wr_deb = i_wr && (i_addr == ESF_ADR_DEBOUNCE);
	wire rd_stat = i_rd && (i_addr == ESF_ADR_IRQ_STAT);
	wire clr_cmd = wr_ctrl && i_wdata[ESF_CTRL_CLEAR];

	// contact polarity: normally closed means a low (open) pin is alarm
	wire estop_active = ctrl_reg[ESF_CTRL_ESTOP_NO] ? estop_pin : !estop_pin;
	wire start_edge = dbi.level && !level_d_reg;
	wire alarm_clear_input_edge = alarm_clear_input_on && !alarm_clear_input_d_reg;
	wire blocked = stop_on || estop_reg || i_other_alarm;
	// priority: busy, blocked, empty, bad command
	wire err_busy = start_edge && busy_reg;
	wire err_block = start_edge && !busy_reg && blocked;
	wire err_empty = start_edge && !busy_reg && !blocked && i_chan_empty;
	wire err_bad = start_edge && !busy_reg && !blocked && !i_chan_empty
		&& (i_chan_bad || !i_servo_on);
	wire go = start_edge && !busy_reg && !blocked && !i_chan_empty
		&& !i_chan_bad && i_servo_on;
	wire any_err = err_busy || err_block || err_empty || err_bad;
	wire estop_rise = estop_active && !estop_reg;
	wire perr_clr = alarm_clear_input_edge || clr_cmd;

	// subcode selection
	esf_sub_t sub_next;
	assign sub_next = err_busy ? ESF_SUB_BUSY :
		err_block ? ESF_SUB_BLOCKED :
		err_empty ? ESF_SUB_EMPTY : ESF_SUB_BADCMD;

	// history entry: code in high nibble, subcode low
	function automatic logic [7:0] hist_entry(input logic [3:0] code, input logic [1:0] sub);
		hist_entry = {code, 2'b00, sub};
	endfunction : hist_entry

	// estop alarm follows the input directly, no latch
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			estop_reg <= 1'b1;
		else if (i_ce)
			estop_reg <= estop_active;
	end

	// program start / busy / error
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			busy_reg <= 1'b0;
			start_reg <= 1'b0;
			chan_reg <= '0;
			perr_reg <= 1'b0;
			sub_reg <= ESF_SUB_BUSY;
			level_d_reg <= 1'b0;
			alarm_clear_input_d_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			level_d_reg <= dbi.level;
			alarm_clear_input_d_reg <= alarm_clear_input_on;
			start_reg <= go;
			if (go)
				chan_reg <= sel2_reg;
			if (go)
				busy_reg <= 1'b1;
			else if (i_prog_done || estop_reg)
				busy_reg <= 1'b0;
			// a new error wins over a clear in the same cycle
			if (any_err)
			begin
				perr_reg <= 1'b1;
				sub_reg <= sub_next;
			end
			else if (perr_clr)
				perr_reg <= 1'b0;
		end
	end

	// alarm history ring
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			hwp_reg <= '0;
			hcnt_reg <= '0;
		end
		else if (i_ce && (any_err || estop_rise))
		begin
			hist_mem[hwp_reg] <= any_err ? hist_entry(ESF_CODE_PRGERR, sub_next)
				: hist_entry(ESF_CODE_ESTOP, 2'b00);
			hwp_reg <= hwp_reg + 1'b1;
			hcnt_reg <= hcnt_reg + 1'b1;
		end
	end

	// software registers; read of status clears, set wins
	wire [ESF_IRQ_W-1:0] irq_set = {any_err, estop_rise};
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			ctrl_reg <= ESF_CTRL_RST;
			deb_reg <= ESF_TMR_W'(DEBOUNCE_CYC);
			irq_mask_reg <= '0;
			irq_stat_reg <= '0;
		end
		else if (i_ce)
		begin
			if (wr_ctrl)
				ctrl_reg <= {31'h0000_0000, i_wdata[ESF_CTRL_ESTOP_NO]};
			if (wr_deb)
				deb_reg <= i_wdata[ESF_TMR_W-1:0];
			if (wr_mask)
				irq_mask_reg <= i_wdata[ESF_IRQ_W-1:0];
			irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg) | irq_set;
		end
	end

	// read mux
	wire [ESF_HIST_AW-1:0] hidx = i_addr[ESF_HIST_AW-1:0];
	wire [31:0] status_word = {26'h000_0000, sub_reg, perr_reg, busy_reg, stop_on,
		estop_reg};
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (i_addr >= ESF_ADR_HIST_BASE)
			rd_mux = {24'h00_0000, hist_mem[hidx]};
		else if (i_addr == ESF_ADR_STATUS)
			rd_mux = status_word;
		else if (i_addr == ESF_ADR_IRQ_STAT)
			rd_mux = {30'h0000_0000, irq_stat_reg};
		else if (i_addr == ESF_ADR_IRQ_MASK)
			rd_mux = {30'h0000_0000, irq_mask_reg};
		else if (i_addr == ESF_ADR_CTRL)
			rd_mux = ctrl_reg;
		else if (i_addr == ESF_ADR_DEBOUNCE)
			rd_mux = {12'h000, deb_reg};
		else if (i_addr == ESF_ADR_HIST_CNT)
			rd_mux = {24'h00_0000, hcnt_reg};
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			rdata_reg <= '0;
		else if (i_ce)
			rdata_reg <= i_rd ? rd_mux : 32'h0000_0000;
	end

	// outputs
	assign o_rdata = rdata_reg;
	assign o_servo_enable = !estop_reg && i_servo_on;
	assign o_dyn_brake = estop_reg;
	assign o_estop_alarm = estop_reg;
	assign o_busy = busy_reg;
	assign o_prog_start = start_reg;
	assign o_prog_channel = chan_reg;
	assign o_prog_error = perr_reg;
	assign o_prog_subcode = sub_reg;
	assign o_irq = |(irq_stat_reg & irq_mask_reg);
endmodule : esf_fault_top
`default_nettype wire

// ===== verilog/esf_pkg.sv
// esf_pkg: shared constants for the emergency-stop / program-start fault block
// assumes a single 100 MHz clock domain
`default_nettype none
package esf_pkg;
	localparam int ESF_CLK_MHZ = 100;
	// channel select must settle this long before a start (host side)
	localparam int ESF_SEL_SETUP_US = 1000;
	localparam int ESF_SEL_SETUP_CYC = ESF_SEL_SETUP_US * ESF_CLK_MHZ;
	// default anti-chatter time in microseconds
	localparam int ESF_DEBOUNCE_US = 10;
	localparam int ESF_DEBOUNCE_CYC = ESF_DEBOUNCE_US * ESF_CLK_MHZ;
	localparam int ESF_TMR_W = 20;
	localparam int ESF_CH_W = 8;
	localparam int ESF_HIST_DEPTH = 8;
	localparam int ESF_HIST_AW = 3;
	// register map (word indices on the plain port)
	localparam logic [3:0] ESF_ADR_STATUS = 4'h0;
	localparam logic [3:0] ESF_ADR_IRQ_STAT = 4'h1;
	localparam logic [3:0] ESF_ADR_IRQ_MASK = 4'h2;
	localparam logic [3:0] ESF_ADR_CTRL = 4'h3;
	localparam logic [3:0] ESF_ADR_DEBOUNCE = 4'h4;
	localparam logic [3:0] ESF_ADR_HIST_CNT = 4'h5;
	localparam logic [3:0] ESF_ADR_HIST_BASE = 4'h8;
	// control register fields
	localparam int ESF_CTRL_ESTOP_NO = 0; // 1 = estop input normally open
	localparam int ESF_CTRL_CLEAR = 1;    // write 1: clear-alarm command
	localparam logic [31:0] ESF_CTRL_RST = 32'h0000_0000;
	// interrupt bit positions
	localparam int ESF_IRQ_ESTOP = 0;
	localparam int ESF_IRQ_PRGERR = 1;
	localparam int ESF_IRQ_W = 2;
	// program error subcodes
	typedef enum logic [1:0] {
		ESF_SUB_BUSY = 2'b00,
		ESF_SUB_EMPTY = 2'b01,
		ESF_SUB_BADCMD = 2'b10,
		ESF_SUB_BLOCKED = 2'b11
	} esf_sub_t;
	localparam logic [3:0] ESF_CODE_ESTOP = 4'h4;
	localparam logic [3:0] ESF_CODE_PRGERR = 4'h5;
endpackage : esf_pkg
`default_nettype wire

// ===== verilog/esf_ctrl_if.sv
// esf_ctrl_if: debounce settings and filtered level between top and filter
// assumes both ends on i_clk
`timescale 1ns/1ps
`default_nettype none
interface esf_ctrl_if
	import esf_pkg::*;
();
	logic [ESF_TMR_W-1:0] limit;
	logic raw;
	logic level;
	modport owner (output limit, output raw, input level);
	modport filter (input limit, input raw, output level);
endinterface : esf_ctrl_if
`default_nettype wire

// ===== verilog/esf_debounce.sv
// esf_debounce: anti-chatter filter, level follows raw after limit+1 stable cycles
// assumes raw is already synchronised to i_clk
`timescale 1ns/1ps
`default_nettype none
module esf_debounce
	import esf_pkg::*;
(
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// settings and result
	esf_ctrl_if.filter dbi
);
	logic [ESF_TMR_W-1:0] cnt_reg;
	logic level_reg;
	wire differs = dbi.raw != level_reg;
	wire expired = cnt_reg >= dbi.limit;

	// restart the count on every bounce so only a stable level passes
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			cnt_reg <= '0;
			level_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			cnt_reg <= (differs && !expired) ? cnt_reg + 1'b1 : '0;
			if (differs && expired)
				level_reg <= dbi.raw;
		end
	end
	assign dbi.level = level_reg;
endmodule : esf_debounce
`default_nettype wire

// ===== bench/esf_fault_top_properties.sv
// esf_fault_props: port-level assertions for the fault supervision top
// assumes the estop pin only moves under default polarity, i_ce held high
`timescale 1ns/1ps
`default_nettype none
module esf_fault_props
	import esf_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// watched pins
	input wire logic i_emergency_stop_input,
	input wire logic i_servo_on,
	// watched outputs
	input wire logic o_servo_enable,
	input wire logic o_dyn_brake,
	input wire logic o_estop_alarm,
	input wire logic o_busy,
	input wire logic o_prog_start
);
	// single domain, so one clock and one reset for all
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	chk_servo_gated: assert property (o_servo_enable == (!o_estop_alarm && i_servo_on))
		else $error("servo enable wrong");
	chk_brake_alarm: assert property (o_estop_alarm |-> o_dyn_brake)
		else $error("brake off in alarm");
	chk_estop_raise: assert property (
		$fell(i_emergency_stop_input) ##1 (!i_emergency_stop_input) [*3] |-> o_estop_alarm)
		else $error("alarm not raised");
	chk_estop_release: assert property (
		$rose(i_emergency_stop_input) ##1 (i_emergency_stop_input) [*3] |-> !o_estop_alarm)
		else $error("alarm not cleared");
	chk_start_single: assert property (o_prog_start |=> !o_prog_start && o_busy)
		else $error("start pulse wrong");
	chk_busy_refuse: assert property (o_busy |=> !o_prog_start)
		else $error("start while busy");
	chk_alarm_blocks: assert property (o_estop_alarm |=> !o_prog_start)
		else $error("start in alarm");
	chk_alarm_ends_busy: assert property (o_estop_alarm [*2] |-> !o_busy)
		else $error("busy kept in alarm");
endmodule : esf_fault_props
bind esf_fault_top esf_fault_props chk (.i_clk, .i_rst_n, .i_emergency_stop_input, .i_servo_on,
	.o_servo_enable, .o_dyn_brake, .o_estop_alarm, .o_busy, .o_prog_start);
`default_nettype wire

// ===== bench/esf_host_model.sv
// esf_host_model: host start pin with contact bounce, plus engine done
// assumes i_go is a one-cycle request from the bench
`timescale 1ns/1ps
`default_nettype none
module esf_host_model
	import esf_pkg::*;
#(
	parameter int SETUP = ESF_SEL_SETUP_CYC,
	parameter int DONE_DLY = 80
)
(
	// clock and requests
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [ESF_CH_W-1:0] i_sel,
	input wire logic i_prog_start,
	// pins to the block
	output logic o_start = 1'b0,
	output logic [ESF_CH_W-1:0] o_sel = '0,
	output logic o_done = 1'b0
);
	int cnt = 0;
	int dcnt = 0;
	// select settles first, then start rises with one bounce
	always @(posedge i_clk)
	begin
		o_done <= (dcnt == 1);
		if (i_prog_start)
			dcnt <= DONE_DLY;
		else if (dcnt > 0)
			dcnt <= dcnt - 1;
		if (i_go)
		begin
			o_sel <= i_sel;
			cnt <= 1;
		end
		else if (cnt > 0)
			cnt <= (cnt == SETUP + 12) ? 0 : cnt + 1;
		o_start <= (cnt == SETUP) || (cnt > SETUP + 1 && cnt < SETUP + 12);
		// released select shows a changed value, not the old one
		if (cnt == SETUP + 12)
			o_sel <= ~o_sel;
	end
endmodule : esf_host_model
`default_nettype wire

// ===== bench/esf_fault_top_bench.sv
// esf_fault_top_bench: self-checking bench for the fault supervision top
// assumes the host model owns the start pin and channel select
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITF(c) begin n = 0; while (!(c) && n < 300) begin @(posedge i_clk); n++; end \
	if (n >= 300) begin fails++; wrap_up(); end end
module esf_fault_top_bench
	import esf_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst_n, i_ce, i_emergency_stop_input, i_stop_input, i_alarm_clear_input, go;
	logic i_servo_on, i_chan_empty, i_chan_bad, i_other_alarm, i_wr, i_rd, o_irq;
	logic i_program_start, i_prog_done, o_servo_enable, o_dyn_brake, o_estop_alarm, o_busy;
	logic o_prog_start, o_prog_error;
	logic [ESF_CH_W-1:0] i_program_channel_select, o_prog_channel, sel;
	logic [1:0] o_prog_subcode;
	logic [3:0] i_addr;
	logic [31:0] i_wdata, o_rdata, d, h;
	int fails = 0;
	int checked = 0;
	int starts = 0;
	int n;
	always #5 i_clk = ~i_clk;
	// accepted starts, so bounce or refusals show up as extra counts
	always @(posedge i_clk)
		if (o_prog_start)
			starts <= starts + 1;
	esf_fault_top #(.DEBOUNCE_CYC(4)) dut (.i_clk, .i_rst_n, .i_ce, .i_emergency_stop_input,
		.i_stop_input, .i_alarm_clear_input, .i_program_start, .i_program_channel_select,
		.i_servo_on, .i_chan_empty, .i_chan_bad, .i_other_alarm, .i_prog_done, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .o_servo_enable, .o_dyn_brake, .o_estop_alarm,
		.o_busy, .o_prog_start, .o_prog_channel, .o_prog_error, .o_prog_subcode, .o_irq);
	esf_host_model #(.SETUP(8)) host (.i_clk, .i_go(go), .i_sel(sel), .i_prog_start(o_prog_start),
		.o_start(i_program_start), .o_sel(i_program_channel_select), .o_done(i_prog_done));
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
		v = o_rdata;
	endtask : rd
	task automatic start(input logic [7:0] s);
		`WAITF(!i_program_start)
		go <= 1'b1;
		sel <= s;
		@(posedge i_clk);
		go <= 1'b0;
	endtask : start
	task automatic t_estop();
		wr(ESF_ADR_IRQ_MASK, 32'h0000_0000);
		i_emergency_stop_input <= 1'b0;
		`WAITF(o_estop_alarm)
		`CHK({o_servo_enable, o_dyn_brake, o_irq}, 3'b010)
		wr(ESF_ADR_IRQ_MASK, 32'h0000_0003);
		@(posedge i_clk);
		`CHK(o_irq, 1'b1)
		i_emergency_stop_input <= 1'b1;
		`WAITF(!o_estop_alarm)
		`CHK({o_servo_enable, o_dyn_brake}, 2'b10)
		rd(ESF_ADR_IRQ_STAT, d);
		`CHK(d[ESF_IRQ_ESTOP], 1'b1)
		`CHK(o_irq, 1'b0)
		// normally-open polarity: a closed (high) pin now means alarm
		wr(ESF_ADR_CTRL, 32'h0000_0001);
		repeat (2) @(posedge i_clk);
		`CHK({o_estop_alarm, o_servo_enable}, 2'b10)
		wr(ESF_ADR_CTRL, 32'h0000_0000);
		`WAITF(!o_estop_alarm)
		`CHK(o_dyn_brake, 1'b0)
		$display("test estop done");
	endtask : t_estop
	task automatic t_busy();
		start(8'hA5);
		`WAITF(o_prog_start)
		`CHK(o_prog_channel, 8'hA5)
		start(8'h3C);
		`CHK(o_prog_error, 1'b0)
		`WAITF(o_prog_error)
		`CHK({o_busy, o_prog_subcode}, 3'b100)
		`CHK(starts, 1)
		i_alarm_clear_input <= 1'b1;
		`WAITF(!o_prog_error)
		i_alarm_clear_input <= 1'b0;
		`WAITF(!o_busy)
		$display("test busy done");
	endtask : t_busy
	task automatic t_errs();
		for (int k = 1; k < 4; k++)
		begin
			i_chan_empty <= (k == 1);
			i_chan_bad <= (k == 2);
			i_stop_input <= (k == 3);
			rd(ESF_ADR_IRQ_STAT, d);
			`CHK(o_irq, 1'b0)
			rd(ESF_ADR_HIST_CNT, h);
			start(8'h0F);
			`WAITF(o_prog_error)
			`CHK({o_prog_subcode, o_irq}, {k[1:0], 1'b1})
			`CHK(starts, 1)
			rd(ESF_ADR_HIST_BASE | {1'b0, h[2:0]}, d);
			`CHK(d[7:0], {ESF_CODE_PRGERR, 2'b00, k[1:0]})
			wr(ESF_ADR_CTRL, 32'h0000_0002);
			@(posedge i_clk);
			`CHK(o_prog_error, 1'b0)
		end
		rd(4'h6, d);
		`CHK(d, 32'h0000_0000)
		$display("test errors done");
	endtask : t_errs
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// main sequence, reset held four cycles
	initial
	begin
		{i_rst_n, i_stop_input, i_alarm_clear_input, i_chan_empty, i_chan_bad} = '0;
		{i_other_alarm, i_wr, i_rd, go, i_addr, i_wdata, sel} = '0;
		{i_ce, i_emergency_stop_input, i_servo_on} = 3'b111;
		repeat (4) @(posedge i_clk);
		`CHK({o_estop_alarm, o_busy}, 2'b10)
		i_rst_n <= 1'b1;
		`WAITF(!o_estop_alarm)
		wr(ESF_ADR_DEBOUNCE, 32'h0000_0002);
		@(posedge i_clk);
		t_estop();
		t_busy();
		t_errs();
		wrap_up();
	end
endmodule : esf_fault_top_bench
`default_nettype wire
